// ==== rtl/pic_cfg.svh ====
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
// Register word indexes, byte address is four times the index
`define PIC_ADR_CTRL 6'h00
`define PIC_ADR_MASK 6'h01
`define PIC_ADR_LATCH 6'h02
`define PIC_ADR_PRIO0 6'h03
`define PIC_ADR_PRIO1 6'h04
`define PIC_ADR_FLAG 6'h05
`define PIC_ADR_EVT 6'h06
`define PIC_ADR_EVTMSK 6'h07
`define PIC_ADR_LEVEL 6'h08
// Control bit positions
`define PIC_BIT_NEST 4
`define PIC_BIT_GIE 5
`define PIC_BIT_MACRND 7
`define PIC_BIT_PCSE 10
`define PIC_BIT_LPSE 11
`define PIC_CTRL_WMASK 16'h0CB0
`define PIC_CTRL_RST 16'h0000
// Latch positions of fixed interrupts
`define PIC_IDX_RESET 0
`define PIC_IDX_PWRDN 1
`define PIC_IDX_STACK 2
`define PIC_IDX_KERNEL 3
`define PIC_NMI_BITS 16'h0003
`define PIC_USER_BASE 4'h4
`define PIC_PRIO_LOW 4'hB
`define PIC_PRIO_RST 60'hBBBBA9876543210
`define PIC_NUM_PERIPH 15
`define PIC_FLAG_ID0 12
// Vector table
`define PIC_VEC_STEP 24'h000020
`define PIC_VEC_EXT 24'h010000
// Stacks
`define PIC_PC_DEPTH 33
`define PIC_LOOP_DEPTH 8
`define PIC_STAT_DEPTH 16
`define PIC_PC_LOW 6'h03
`define PIC_PC_HIGH 6'h1C
`endif

// ==== rtl/pic_pkg.sv ====
package pic_pkg;
`include "pic_cfg.svh"
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pic_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pic_wb_rsp_t;
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } pic_vec_t;
  typedef enum logic [1:0] {PIC_FLAG_LEVEL, PIC_FLAG_RISE, PIC_FLAG_BOTH} pic_flag_mode_t;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] mask;
    logic [15:0] latch;
    logic [`PIC_NUM_PERIPH-1:0][3:0] prio;
    logic [3:0] flag_cfg;
    logic [1:0] flag_prev;
    logic [3:0] evt;
    logic [3:0] evt_msk;
    logic [15:0] isr;
    logic [3:0] vec_idx;
    pic_vec_t vec;
    logic emu;
    logic irq;
    logic [`PIC_PC_DEPTH-1:0][23:0] pc_stk;
    logic [5:0] pc_cnt;
    logic [`PIC_LOOP_DEPTH-1:0][23:0] lp_stk;
    logic [3:0] lp_cnt;
    logic [`PIC_STAT_DEPTH-1:0][15:0] st_stk;
    logic [4:0] st_cnt;
    logic [23:0] ret_pc;
    logic [15:0] ret_stat;
    logic [23:0] lp_top;
    pic_wb_rsp_t wb;
  } pic_state_t;
endpackage

// ==== rtl/pic_top.sv ====
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "pic_cfg.svh"
// Overview of operation
// - Seventeen sources, emulator highest, never latched
// - Bits 0-15 vector at 0x20 steps
// - No-boot external mode moves table to 0x10000
// - Reset, power-down, emulator ignore mask; disable blocks power-down
// - Peripheral priorities reset to ID, 12-14 to 11
// - Writable priority field per peripheral ID
// - Priority p uses latch bit p+4
// - Priority 11 shares bit 15 vector
// - Latch AND mask, highest unmasked wins
// - Nesting bit allows preemption, else sequential
// - Control: nest, enable, rounding, stack enables
// - Enable/disable instructions gate servicing globally
// - Servicing disabled after reset
// - Software write sets or clears latch bits
// - PC 33, loop 8, status 16 stacks
// - PC stack below 3 or above 28 interrupts
// - Flag pins level, rising or both edges
module pic_top (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_nrst,
  // Register bus
  input pic_pkg::pic_wb_req_t i_wb,
  output pic_pkg::pic_wb_rsp_t o_wb,
  // Interrupt sources
  input logic i_emu_req,
  input logic i_reset_req,
  input logic i_pwrdn_req,
  input logic i_kernel_req,
  input logic [`PIC_NUM_PERIPH-1:0] i_periph_req,
  input logic [1:0] i_programmable_flag_pin,
  // Program sequencer
  input logic i_global_enable_instruction,
  input logic i_global_disable_instruction,
  input logic i_no_boot_ext,
  input logic i_vec_take,
  input logic i_rti,
  input logic [23:0] i_pc,
  input logic [15:0] i_status,
  input logic i_loop_push,
  input logic i_loop_pop,
  input logic [23:0] i_loop_dat,
  // Answers to the sequencer
  output pic_pkg::pic_vec_t o_vec,
  output logic o_emu_irq,
  output logic [23:0] o_ret_pc,
  output logic [15:0] o_ret_stat,
  output logic [23:0] o_loop_top,
  output logic o_mac_round,
  output logic o_irq
);

  pic_pkg::pic_state_t s_q;
  pic_pkg::pic_state_t s_d;
  logic acc;
  logic wr;
  logic [5:0] widx;
  logic [31:0] wm;
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [15:0] elig;
  logic [3:0] evt_new;
  logic [1:0] flag_req;
  logic [3:0] p;
  logic [3:0] sel_idx;
  logic sel_hit;
  logic [3:0] top_isr;
  logic isr_hit;
  logic take_set;
  pic_pkg::pic_flag_mode_t fmode;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  assign acc = i_wb.cyc & i_wb.stb & ~s_q.wb.ack;
  assign wr = acc & i_wb.we;
  assign widx = i_wb.adr[7:2];
  assign wm = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}}, {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
  assign take_set = set_v[s_q.vec_idx];

  // ****************************************
  // Request collection
  // ****************************************
  always_comb begin
    set_v = 16'h0000;
    flag_req = 2'b00;
    p = 4'h0;
    fmode = pic_pkg::PIC_FLAG_LEVEL;
    // Flag pins feed peripheral IDs 12 and 13
    for (int f = 0; f < 2; f++) begin
      fmode = pic_pkg::pic_flag_mode_t'(s_q.flag_cfg[2*f +: 2]);
      unique case (fmode)
        pic_pkg::PIC_FLAG_LEVEL: begin
          flag_req[f] = i_programmable_flag_pin[f];
        end
        pic_pkg::PIC_FLAG_RISE: begin
          flag_req[f] = i_programmable_flag_pin[f] & ~s_q.flag_prev[f];
        end
        pic_pkg::PIC_FLAG_BOTH: begin
          flag_req[f] = i_programmable_flag_pin[f] ^ s_q.flag_prev[f];
        end
        default: begin
          flag_req[f] = i_programmable_flag_pin[f];
        end
      endcase
    end
    set_v[`PIC_IDX_RESET] = i_reset_req;
    set_v[`PIC_IDX_PWRDN] = i_pwrdn_req;
    set_v[`PIC_IDX_KERNEL] = i_kernel_req;
    // Level condition: re-latches while the stack stays outside its band
    set_v[`PIC_IDX_STACK] = (s_q.ctrl[`PIC_BIT_PCSE] & ((s_q.pc_cnt < `PIC_PC_LOW) |
                            (s_q.pc_cnt > `PIC_PC_HIGH))) |
                            (s_q.ctrl[`PIC_BIT_LPSE] & (s_q.lp_cnt == 4'(`PIC_LOOP_DEPTH)));
    for (int id = 0; id < `PIC_NUM_PERIPH; id++) begin
      p = s_q.prio[id];
      // Codes above 11 alias onto the lowest slot as well
      if (p > `PIC_PRIO_LOW) begin
        p = `PIC_PRIO_LOW;
      end
      if ((id == `PIC_FLAG_ID0) || (id == `PIC_FLAG_ID0 + 1)) begin
        if (flag_req[id - `PIC_FLAG_ID0]) begin
          set_v[p + `PIC_USER_BASE] = 1'b1;
        end
      end else if (i_periph_req[id]) begin
        set_v[p + `PIC_USER_BASE] = 1'b1;
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    evt_new = 4'h0;
    clr_v = 16'h0000;
    elig = 16'h0000;
    sel_idx = 4'h0;
    sel_hit = 1'b0;
    top_isr = 4'hF;
    isr_hit = 1'b0;
    s_d.flag_prev = i_programmable_flag_pin;
    s_d.emu = i_emu_req;

    // Register writes
    if (wr) begin
      unique case (widx)
        `PIC_ADR_CTRL: begin
          s_d.ctrl = 16'(merge({16'h0000, s_q.ctrl}, i_wb.dat, wm)) &
                     `PIC_CTRL_WMASK;
        end
        `PIC_ADR_MASK: begin
          s_d.mask = 16'(merge({16'h0000, s_q.mask}, i_wb.dat, wm));
        end
        `PIC_ADR_LATCH: begin
          s_d.latch = 16'(merge({16'h0000, s_q.latch}, i_wb.dat, wm));
        end
        `PIC_ADR_PRIO0: begin
          s_d.prio[7:0] = merge(s_q.prio[7:0], i_wb.dat, wm);
        end
        `PIC_ADR_PRIO1: begin
          s_d.prio[14:8] = 28'(merge({4'h0, s_q.prio[14:8]}, i_wb.dat, wm));
        end
        `PIC_ADR_FLAG: begin
          s_d.flag_cfg = 4'(merge({28'h0, s_q.flag_cfg}, i_wb.dat, wm));
        end
        `PIC_ADR_EVT: begin
          s_d.evt = s_q.evt & ~(i_wb.dat[3:0] & wm[3:0]);
        end
        `PIC_ADR_EVTMSK: begin
          s_d.evt_msk = 4'(merge({28'h0, s_q.evt_msk}, i_wb.dat, wm));
        end
        default: begin
        end
      endcase
    end
    // Disable wins when both instructions coincide
    if (i_global_enable_instruction) begin
      s_d.ctrl[`PIC_BIT_GIE] = 1'b1;
    end
    if (i_global_disable_instruction) begin
      s_d.ctrl[`PIC_BIT_GIE] = 1'b0;
    end

    // Interrupt entry
    if (i_vec_take && s_q.vec.valid) begin
      clr_v[s_q.vec_idx] = 1'b1;
      s_d.isr[s_q.vec_idx] = 1'b1;
      if (s_q.pc_cnt < 6'(`PIC_PC_DEPTH)) begin
        s_d.pc_stk[s_q.pc_cnt] = i_pc;
        s_d.pc_cnt = s_q.pc_cnt + 6'h01;
      end else begin
        evt_new[0] = 1'b1;
      end
      if (s_q.st_cnt < 5'(`PIC_STAT_DEPTH)) begin
        s_d.st_stk[s_q.st_cnt[3:0]] = i_status;
        s_d.st_cnt = s_q.st_cnt + 5'h01;
      end
    end else if (i_rti) begin
      // Leave the highest-priority service in progress
      for (int i = 15; i >= 0; i--) begin
        if (s_q.isr[i]) begin
          top_isr = 4'(i);
          isr_hit = 1'b1;
        end
      end
      if (isr_hit) begin
        s_d.isr[top_isr] = 1'b0;
      end
      if (s_q.pc_cnt != 6'h00) begin
        s_d.ret_pc = s_q.pc_stk[s_q.pc_cnt - 6'h01];
        s_d.pc_cnt = s_q.pc_cnt - 6'h01;
      end else begin
        evt_new[1] = 1'b1;
      end
      if (s_q.st_cnt != 5'h00) begin
        s_d.ret_stat = s_q.st_stk[4'(s_q.st_cnt - 5'h01)];
        s_d.st_cnt = s_q.st_cnt - 5'h01;
      end
    end

    // Loop stack
    if (i_loop_push) begin
      if (s_q.lp_cnt < 4'(`PIC_LOOP_DEPTH)) begin
        s_d.lp_stk[s_q.lp_cnt[2:0]] = i_loop_dat;
        s_d.lp_cnt = s_q.lp_cnt + 4'h1;
      end else begin
        evt_new[2] = 1'b1;
      end
    end else if (i_loop_pop) begin
      if (s_q.lp_cnt != 4'h0) begin
        s_d.lp_cnt = s_q.lp_cnt - 4'h1;
      end else begin
        evt_new[3] = 1'b1;
      end
    end
    s_d.lp_top = (s_d.lp_cnt == 4'h0) ? 24'h000000 : s_d.lp_stk[3'(s_d.lp_cnt - 4'h1)];

    // New request wins over a clear in the same cycle
    s_d.latch = (s_d.latch & ~clr_v) | set_v;
    s_d.evt = s_d.evt | evt_new;
    s_d.irq = |(s_d.evt & s_d.evt_msk);

    // Selection from the state that will hold next cycle
    elig = s_d.latch & (s_d.mask | `PIC_NMI_BITS);
    if (!s_d.ctrl[`PIC_BIT_GIE]) begin
      elig = elig & 16'h0001;
    end
    for (int i = 15; i >= 0; i--) begin
      if (elig[i]) begin
        sel_idx = 4'(i);
        sel_hit = 1'b1;
      end
    end
    top_isr = 4'hF;
    isr_hit = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (s_d.isr[i]) begin
        top_isr = 4'(i);
        isr_hit = 1'b1;
      end
    end
    if (isr_hit && !(s_d.ctrl[`PIC_BIT_NEST] && (sel_idx < top_isr))) begin
      sel_hit = 1'b0;
    end
    if (i_emu_req) begin
      sel_hit = 1'b0;
    end
    s_d.vec_idx = sel_idx;
    s_d.vec.valid = sel_hit;
    s_d.vec.addr = (i_no_boot_ext ? `PIC_VEC_EXT : 24'h000000) +
                   24'(`PIC_VEC_STEP * {20'h00000, sel_idx});

    // Bus answer, one wait-free cycle after the request
    s_d.wb.ack = acc;
    s_d.wb.dat = 32'h00000000;
    if (acc && !i_wb.we) begin
      unique case (widx)
        `PIC_ADR_CTRL: s_d.wb.dat = {16'h0000, s_q.ctrl};
        `PIC_ADR_MASK: s_d.wb.dat = {16'h0000, s_q.mask};
        `PIC_ADR_LATCH: s_d.wb.dat = {16'h0000, s_q.latch};
        `PIC_ADR_PRIO0: s_d.wb.dat = s_q.prio[7:0];
        `PIC_ADR_PRIO1: s_d.wb.dat = {4'h0, s_q.prio[14:8]};
        `PIC_ADR_FLAG: s_d.wb.dat = {28'h0000000, s_q.flag_cfg};
        `PIC_ADR_EVT: s_d.wb.dat = {28'h0000000, s_q.evt};
        `PIC_ADR_EVTMSK: s_d.wb.dat = {28'h0000000, s_q.evt_msk};
        `PIC_ADR_LEVEL: s_d.wb.dat = {s_q.isr, 1'b0, s_q.st_cnt, s_q.lp_cnt, s_q.pc_cnt};
        default: s_d.wb.dat = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
      s_q.ctrl <= `PIC_CTRL_RST;
      s_q.prio <= `PIC_PRIO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_wb = s_q.wb;
  assign o_vec = s_q.vec;
  assign o_emu_irq = s_q.emu;
  assign o_ret_pc = s_q.ret_pc;
  assign o_ret_stat = s_q.ret_stat;
  assign o_loop_top = s_q.lp_top;
  assign o_mac_round = s_q.ctrl[`PIC_BIT_MACRND];
  assign o_irq = s_q.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  emu_block_a: assert property (i_emu_req |=> !o_vec.valid && o_emu_irq)
    else $error("vector offered while emulator request pending");
  vec_step_a: assert property (o_vec.valid |-> o_vec.addr[4:0] == 5'h00 &&
                               o_vec.addr[8:5] == s_q.vec_idx && o_vec.addr[15:9] == 7'h00)
    else $error("vector address not slot times 0x20");
  ext_base_a: assert property (o_vec.valid |->
                               o_vec.addr[23:16] == ($past(i_no_boot_ext) ? 8'h01 : 8'h00))
    else $error("vector table base wrong for boot mode");
  pwr_gie_a: assert property (o_vec.valid && s_q.vec_idx == 4'h1 |->
                              s_q.ctrl[`PIC_BIT_GIE])
    else $error("power-down vectored while globally disabled");
  mask_gate_a: assert property (o_vec.valid && s_q.vec_idx > 4'h1 |->
                                s_q.mask[s_q.vec_idx] && s_q.ctrl[`PIC_BIT_GIE] &&
                                s_q.latch[s_q.vec_idx])
    else $error("masked or disabled interrupt vectored");
  seq_serv_a: assert property (o_vec.valid && !s_q.ctrl[`PIC_BIT_NEST] |->
                               s_q.isr == 16'h0000)
    else $error("preemption without nesting enabled");
  rst_state_a: assert property (!$past(i_nrst) |-> !s_q.ctrl[`PIC_BIT_GIE] &&
                                s_q.prio == `PIC_PRIO_RST)
    else $error("reset state of enable or priorities wrong");
  take_clr_a: assert property (i_vec_take && o_vec.valid |=>
                               s_q.isr[$past(s_q.vec_idx)] &&
                               s_q.latch[$past(s_q.vec_idx)] == $past(take_set))
    else $error("taken interrupt still latched");
  pc_lvl_a: assert property (s_q.ctrl[`PIC_BIT_PCSE] &&
                             (s_q.pc_cnt < `PIC_PC_LOW || s_q.pc_cnt > `PIC_PC_HIGH) |=>
                             s_q.latch[`PIC_IDX_STACK])
    else $error("stack level interrupt not latched");

endmodule

// ==== sim/pic_seq_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Sequencer model: takes offered vectors, returns later
// ****************************************
module pic_seq_model #(
  parameter int RTI_DLY = 4
) (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_nrst,
  // Bench control and offered vector
  input logic i_hold,
  input pic_pkg::pic_vec_t i_vec,
  // Answers to the controller
  output logic o_vec_take,
  output logic o_rti,
  output logic [23:0] o_pc,
  output logic [15:0] o_status
);
  logic busy_q;
  logic [7:0] cnt_q;
  // One handler at a time, so nothing is taken before the return
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      o_vec_take <= 1'b0;
      o_rti <= 1'b0;
      o_pc <= 24'h000100;
      o_status <= 16'h0000;
    end else begin
      o_vec_take <= 1'b0;
      o_rti <= 1'b0;
      if (busy_q) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == 8'(RTI_DLY)) begin
          o_rti <= 1'b1;
          busy_q <= 1'b0;
        end
      end else if (i_vec.valid && !i_hold) begin
        o_vec_take <= 1'b1;
        busy_q <= 1'b1;
        cnt_q <= 8'h00;
        o_pc <= o_pc + 24'h000004;
        o_status <= ~o_status;
      end
    end
  end
endmodule

// ==== sim/prioritized_interrupt_controller_bench.sv ====
`timescale 1ns/1ps
module prioritized_interrupt_controller_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  pic_pkg::pic_wb_req_t wbq = '0;
  pic_pkg::pic_wb_rsp_t wbs;
  pic_pkg::pic_vec_t vec;
  logic emu = 1'b0, rq = 1'b0, pd = 1'b0, ena = 1'b0, dis = 1'b0, nbe = 1'b0, pop = 1'b0;
  logic hold = 1'b1;
  logic emu_irq, mac, irq, take, rti;
  logic [14:0] per = '0;
  logic [1:0] pin = '0;
  logic [23:0] pc;
  logic [15:0] st;
  logic [23:0] rpc, ltop;
  logic [15:0] rstat;
  logic push = 1'b0;
  logic [23:0] ldat = '0;
  logic [31:0] r;
  int n_fail = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  pic_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_wb(wbq), .o_wb(wbs), .i_emu_req(emu),
    .i_reset_req(rq), .i_pwrdn_req(pd), .i_kernel_req(1'b0), .i_periph_req(per),
    .i_programmable_flag_pin(pin), .i_global_enable_instruction(ena),
    .i_global_disable_instruction(dis), .i_no_boot_ext(nbe), .i_vec_take(take), .i_rti(rti),
    .i_pc(pc), .i_status(st), .i_loop_push(push), .i_loop_pop(pop), .i_loop_dat(ldat),
    .o_vec(vec), .o_emu_irq(emu_irq), .o_ret_pc(rpc), .o_ret_stat(rstat), .o_loop_top(ltop),
    .o_mac_round(mac), .o_irq(irq));
  pic_seq_model #(.RTI_DLY(4)) seq (.i_sys_clk(clk), .i_nrst(nrst), .i_hold(hold),
    .i_vec(vec), .o_vec_take(take), .o_rti(rti), .o_pc(pc), .o_status(st));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbq <= {1'b1, 1'b1, we, a, 4'hF, d};
    // Ack is looked at as sampled by the edge itself
    do begin
      @(posedge clk);
      n++;
    end while (wbs.ack !== 1'b1 && n < 50);
    if (wbs.ack !== 1'b1) begin
      n_fail++;
      $display("Error bus ack expected 1 seen %b", wbs.ack);
    end
    r = wbs.dat;
    wbq <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
    wb(1'b0, a, 32'h0);
    chk(w, e, r);
  endtask
  task automatic bit_is(input string w, input int k, input logic e);
    logic [2:0] b;
    #1;
    b = {emu_irq, mac, irq};
    chk(w, {31'h0, e}, {31'h0, b[k]});
    @(posedge clk);
  endtask
  // Hold the sequencer off while looking, then let it take once
  task automatic vec_is(input logic [23:0] e);
    int n;
    n = 0;
    #1;
    while (vec.valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("vector", {8'h01, e}, {7'h0, vec});
    @(posedge clk);
    hold <= 1'b0;
    @(posedge clk);
    hold <= 1'b1;
    repeat (10) @(posedge clk);
    chk("return pc", {8'h0, pc}, {8'h0, rpc});
    chk("return status", {16'h0, st}, {16'h0, rstat});
  endtask
  task automatic no_vec(input string w);
    repeat (8) begin
      @(posedge clk);
      #1;
      chk(w, 32'h0, {31'h0, vec.valid});
    end
    @(posedge clk);
  endtask
  task automatic pulse(input logic [14:0] p);
    per <= p;
    @(posedge clk);
    per <= '0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd(8'h00, 32'h0, "control");
    rd(8'h0C, 32'h76543210, "prio_lo");
    rd(8'h10, 32'h0BBBBA98, "prio_hi");
    rd(8'h24, 32'h0, "unmapped");
    wb(1'b1, 8'h00, 32'h0000FFFF);
    rd(8'h00, 32'h00000CB0, "control");
    bit_is("rounding", 1, 1'b1);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h0);
  endtask
  task automatic t_slots;
    ena <= 1'b1;
    @(posedge clk);
    ena <= 1'b0;
    wb(1'b1, 8'h04, 32'h0000FFF0);
    for (int id = 0; id < 15; id++) begin
      if (id != 12 && id != 13) begin
        pulse(15'h0001 << id);
        vec_is(id < 11 ? 24'h80 + 24'(id) * 24'h20 : 24'h1E0);
      end
    end
  endtask
  task automatic t_emu;
    emu <= 1'b1;
    pulse(15'h0002);
    bit_is("emulator", 2, 1'b1);
    no_vec("emulator block");
    emu <= 1'b0;
    vec_is(24'h0000A0);
  endtask
  task automatic t_prio;
    wb(1'b1, 8'h0C, 32'h76543212);
    rd(8'h0C, 32'h76543212, "prio_lo");
    pulse(15'h0001);
    vec_is(24'h0000C0);
  endtask
  task automatic t_flags;
    pin <= 2'b01;
    vec_is(24'h0001E0);
    vec_is(24'h0001E0);
    wb(1'b1, 8'h14, 32'h1);
    pin <= 2'b00;
    wb(1'b1, 8'h08, 32'h0);
    pin <= 2'b01;
    vec_is(24'h0001E0);
    no_vec("edge flag");
    wb(1'b1, 8'h14, 32'h2);
    pin <= 2'b00;
    vec_is(24'h0001E0);
  endtask
  task automatic t_latch;
    wb(1'b1, 8'h04, 32'h0000FF70);
    pulse(15'h0008);
    no_vec("masked");
    rd(8'h08, 32'h00000080, "latch");
    wb(1'b1, 8'h08, 32'h0);
    rd(8'h08, 32'h0, "latch");
    wb(1'b1, 8'h04, 32'h0000FFF0);
    wb(1'b1, 8'h08, 32'h00000180);
    vec_is(24'h0000E0);
    rd(8'h08, 32'h00000100, "latch");
    vec_is(24'h000100);
  endtask
  // Sequencer stays busy, so the higher request is only offered
  task automatic t_nest;
    wb(1'b1, 8'h00, 32'h00000030);
    pulse(15'h0020);
    @(posedge clk);
    hold <= 1'b0;
    @(posedge clk);
    hold <= 1'b1;
    pulse(15'h0002);
    #1;
    chk("nested vector", {8'h01, 24'h0000A0}, {7'h0, vec});
    repeat (8) @(posedge clk);
    vec_is(24'h0000A0);
    wb(1'b1, 8'h00, 32'h00000020);
  endtask
  task automatic t_events;
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    rd(8'h18, 32'h8, "event");
    bit_is("irq", 0, 1'b0);
    wb(1'b1, 8'h1C, 32'h8);
    bit_is("irq", 0, 1'b1);
    wb(1'b1, 8'h18, 32'h8);
    bit_is("irq", 0, 1'b0);
  endtask
  task automatic t_stack;
    wb(1'b1, 8'h04, 32'h00000004);
    no_vec("stack off");
    wb(1'b1, 8'h00, 32'h00000420);
    vec_is(24'h000040);
    wb(1'b1, 8'h00, 32'h00000020);
    wb(1'b1, 8'h08, 32'h0);
  endtask
  task automatic t_nmi;
    wb(1'b1, 8'h04, 32'h0);
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    vec_is(24'h000020);
    dis <= 1'b1;
    @(posedge clk);
    dis <= 1'b0;
    rd(8'h00, 32'h0, "control");
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    no_vec("powerdown");
    wb(1'b1, 8'h08, 32'h0);
    nbe <= 1'b1;
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
    vec_is(24'h010000);
    nbe <= 1'b0;
  endtask
  task automatic t_loop;
    push <= 1'b1;
    ldat <= 24'h000111;
    @(posedge clk);
    ldat <= 24'h000222;
    @(posedge clk);
    push <= 1'b0;
    pop <= 1'b1;
    #1;
    chk("loop top", 32'h00000222, {8'h0, ltop});
    @(posedge clk);
    pop <= 1'b0;
    #1;
    chk("loop top", 32'h00000111, {8'h0, ltop});
    @(posedge clk);
    rd(8'h20, 32'h00000040, "levels");
  endtask
  task automatic t_reset;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h0, "control after reset");
    rd(8'h0C, 32'h76543210, "prio_lo after reset");
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    no_vec("disabled after reset");
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_slots();
    t_emu();
    t_prio();
    t_flags();
    t_latch();
    t_nest();
    t_events();
    t_stack();
    t_nmi();
    t_loop();
    t_reset();
    end_of_test();
  end
endmodule
